// ==== logic/hcim_event_mask.sv ====
// Host event flags, per-event masks and global enable driving the host irq pin.
// Assumes event inputs are single-cycle pulses on clk; transferEndPin is an async pin.
// Function
// - Flag bit 2 is set when the last descriptor of iso list buffer B completes.
// - Flag bit 1 is set when the last descriptor of iso list buffer A completes.
// - Flag bit 0 is set when the controller enters the start-of-frame state.
// - The mask register holds ten bits, 9 to 0, matching the flag positions.
// - Each mask bit works together with the global enable bit to let a flag interrupt.
// - All mask bits are zero after reset so the irq pin stays inactive.
// - Writing 1 to a mask bit enables its event and writing 0 disables it.
// - Mask bit 4 gates the operational register cause event.
// - Mask bit 5 gates suspend entry and mask bit 6 gates clock ready.
// - Mask bits 9 and 8 gate the dual role and ack list events; bits 15 to 10 reserved.
// - Flag bits 9 to 3 report the dual role, ack list, periodic ack, clock ready,
//       suspend, operational cause and transfer end events.
// - The transfer end flag sets on counter zero or on the external transfer end pin.
`timescale 1ns/1ps
`default_nettype none
`include "hcim_map.svh"

module hcim_event_mask #(
    parameter int NUM_EVENTS = `HCIM_NUM_EVENTS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire hcim_pkg::hcim_evt_s events,
    input wire logic transferEndPin,
    input wire hcim_pkg::hcim_avm_req_s avmReq,
    output hcim_pkg::hcim_avm_rsp_s avmRsp,
    output logic hostIrqPin
);
    import hcim_pkg::*;

    if (NUM_EVENTS != `HCIM_NUM_EVENTS)
    begin : gChk
        $error("hcim_event_mask serves exactly ten events");
    end

    // Reset release synchroniser
    logic rstSync1_r;
    logic rstSync2_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end
        else
        begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    wire logic sysRst_n = rstSync2_r;

    // Pin synchroniser and rising-edge detect; stage 2 is compared with stage 3
    logic endPinSync1_r;
    logic endPinSync2_r;
    logic endPinSync3_r;
    always_ff @(posedge clk or negedge sysRst_n)
    begin
        if (!sysRst_n)
        begin
            endPinSync1_r <= 1'b0;
            endPinSync2_r <= 1'b0;
            endPinSync3_r <= 1'b0;
        end
        else
        begin
            endPinSync1_r <= transferEndPin;
            endPinSync2_r <= endPinSync1_r;
            endPinSync3_r <= endPinSync2_r;
        end
    end
    wire logic endPinRise = endPinSync2_r & ~endPinSync3_r;

    // Event vector in flag bit order
    hcim_evt_t setVec;
    assign setVec[`HCIM_BIT_FRAME_START] = events.frameStart;
    assign setVec[`HCIM_BIT_ISO_A] = events.isoListADone;
    assign setVec[`HCIM_BIT_ISO_B] = events.isoListBDone;
    assign setVec[`HCIM_BIT_XFER_END] = events.counterZero | endPinRise;
    assign setVec[`HCIM_BIT_OPER_CAUSE] = events.operationalCause;
    assign setVec[`HCIM_BIT_SUSPEND] = events.suspendEntry;
    assign setVec[`HCIM_BIT_CLK_READY] = events.clockReady;
    assign setVec[`HCIM_BIT_PERIODIC_ACK] = events.periodicListAck;
    assign setVec[`HCIM_BIT_ACK_LIST] = events.ackListDone;
    assign setVec[`HCIM_BIT_DUAL_ROLE] = events.dualRole;

    // Bus decode; writes answer in one cycle without waitrequest, reads stall one cycle
    wire logic selFlags = avmReq.address == `HCIM_ADDR_FLAGS;
    wire logic selMask = avmReq.address == `HCIM_ADDR_MASK;
    wire logic selCfg = avmReq.address == `HCIM_ADDR_CFG;
    wire logic wrLo = avmReq.write & avmReq.byteenable[0];
    wire logic wrHi = avmReq.write & avmReq.byteenable[1];
    wire logic [15:0] wdat = avmReq.writedata[15:0];

    hcim_evt_t flags_r;
    hcim_evt_t flags_nxt;
    hcim_evt_t mask_r;
    hcim_evt_t mask_nxt;
    logic globalEn_r;
    logic globalEn_nxt;
    hcim_evt_t wrLane;
    hcim_evt_t flagClr;

    // Byte-lane enable per bit: bits 7..0 on lane 0, 9..8 on lane 1
    assign wrLane = {{2{wrHi}}, {8{wrLo}}};
    // Writing 1 to a flag bit clears it; a same-cycle event wins
    assign flagClr = selFlags ? (wrLane & wdat[NUM_EVENTS-1:0]) : '0;
    assign flags_nxt = (flags_r & ~flagClr) | setVec;
    assign mask_nxt = selMask ?
        ((mask_r & ~wrLane) | (wrLane & wdat[NUM_EVENTS-1:0])) : mask_r;
    assign globalEn_nxt = (selCfg & wrLo) ? wdat[`HCIM_BIT_GLOBAL_EN] : globalEn_r;

    always_ff @(posedge clk or negedge sysRst_n)
    begin
        if (!sysRst_n)
        begin
            flags_r <= `HCIM_RST_FLAGS;
            mask_r <= `HCIM_RST_MASK;
            globalEn_r <= `HCIM_RST_CFG;
        end
        else
        begin
            flags_r <= flags_nxt;
            mask_r <= mask_nxt;
            globalEn_r <= globalEn_nxt;
        end
    end

    // Per-bit gating, then the global enable
    hcim_evt_t gated;
    assign gated = flags_r & mask_r;
    wire logic irqNxt = globalEn_r & (|gated);

    logic irq_r;
    always_ff @(posedge clk or negedge sysRst_n)
    begin
        if (!sysRst_n)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= irqNxt;
        end
    end
    assign hostIrqPin = irq_r;

    // Read data registered; reserved bits read as zero
    wire logic [31:0] rdMux =
        selFlags ? {22'h0, flags_r} :
        selMask ? {22'h0, mask_r} :
        selCfg ? {31'h0, globalEn_r} : `HCIM_UNMAPPED_DATA;

    logic [31:0] rdData_r;
    logic rdValid_r;
    always_ff @(posedge clk or negedge sysRst_n)
    begin
        if (!sysRst_n)
        begin
            rdData_r <= 32'h00000000;
            rdValid_r <= 1'b0;
        end
        else
        begin
            rdData_r <= avmReq.read ? rdMux : rdData_r;
            rdValid_r <= avmReq.read;
        end
    end

    // Reads hold waitrequest one cycle so registered data stand at the accepting edge
    wire logic rdWait = avmReq.read & ~rdValid_r;
    wire logic rdDone = rdValid_r & avmReq.read;
    assign avmRsp = '{readdata: rdData_r, waitrequest: rdWait, readdatavalid: rdDone};

endmodule : hcim_event_mask
`default_nettype wire

// ==== logic/hcim_map.svh ====
// Register map, field positions and reset values of the host event mask block.
// Assumes a 16-bit register view in the low bits of a 32-bit Avalon-MM word.
`ifndef HCIM_MAP_SVH
`define HCIM_MAP_SVH

// Word indices as printed; byte address is four times the index
`define HCIM_IDX_FLAGS 8'h24
`define HCIM_IDX_MASK 8'h25
`define HCIM_IDX_CFG 8'h20
`define HCIM_ADDR_FLAGS 10'h090
`define HCIM_ADDR_MASK 10'h094
`define HCIM_ADDR_CFG 10'h080

`define HCIM_NUM_EVENTS 10
`define HCIM_BIT_FRAME_START 0
`define HCIM_BIT_ISO_A 1
`define HCIM_BIT_ISO_B 2
`define HCIM_BIT_XFER_END 3
`define HCIM_BIT_OPER_CAUSE 4
`define HCIM_BIT_SUSPEND 5
`define HCIM_BIT_CLK_READY 6
`define HCIM_BIT_PERIODIC_ACK 7
`define HCIM_BIT_ACK_LIST 8
`define HCIM_BIT_DUAL_ROLE 9
`define HCIM_BIT_GLOBAL_EN 0

`define HCIM_RST_MASK 10'h000
`define HCIM_RST_FLAGS 10'h000
`define HCIM_RST_CFG 1'h0
`define HCIM_UNMAPPED_DATA 32'h00000000

`endif

// ==== logic/hcim_pkg.sv ====
// Types shared by the host event mask block.
// Assumes hcim_map.svh is on the include path.
`include "hcim_map.svh"

package hcim_pkg;

    typedef logic [`HCIM_NUM_EVENTS-1:0] hcim_evt_t;

    // Event sources, one-cycle pulses on the system clock
    typedef struct packed {
        logic dualRole;
        logic ackListDone;
        logic periodicListAck;
        logic clockReady;
        logic suspendEntry;
        logic operationalCause;
        logic counterZero;
        logic isoListBDone;
        logic isoListADone;
        logic frameStart;
    } hcim_evt_s;

    typedef struct packed {
        logic [9:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } hcim_avm_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
        logic readdatavalid;
    } hcim_avm_rsp_s;

endpackage : hcim_pkg

// ==== verif/hcim_event_mask_props.sv ====
// Port checks for the host event mask block.
// Assumes one clk domain and active-low rst_n.
`timescale 1ns/1ps
`default_nettype none
`include "hcim_map.svh"
module hcim_event_mask_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire hcim_pkg::hcim_evt_s events,
    input wire logic transferEndPin,
    input wire hcim_pkg::hcim_avm_req_s avmReq,
    input wire hcim_pkg::hcim_avm_rsp_s avmRsp,
    input wire logic hostIrqPin
);
    import hcim_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic wrCfg = avmReq.write && avmReq.address == `HCIM_ADDR_CFG;
    wire logic wrMask = avmReq.write && avmReq.address == `HCIM_ADDR_MASK;
    property p_rst; $rose(rst_n) |-> !hostIrqPin [*2]; endproperty
    a_rst: assert property (p_rst) else $error("irq after reset");
    property p_rdw; $rose(avmReq.read) |-> avmRsp.waitrequest ##1 !avmRsp.waitrequest; endproperty
    a_rdw: assert property (p_rdw) else $error("read wait");
    property p_wr; avmReq.write |-> !avmRsp.waitrequest; endproperty
    a_wr: assert property (p_wr) else $error("write wait");
    property p_rdv; avmReq.read && !avmRsp.waitrequest |-> avmRsp.readdatavalid; endproperty
    a_rdv: assert property (p_rdv) else $error("no valid");
    property p_hi; avmRsp.readdatavalid |-> avmRsp.readdata[31:10] == '0; endproperty
    a_hi: assert property (p_hi) else $error("reserved bits");
    property p_hold; !avmReq.read |=> $stable(avmRsp.readdata); endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_cfg; wrCfg && avmReq.byteenable[0] && !avmReq.writedata[0] |-> ##2 !hostIrqPin;
    endproperty
    a_cfg: assert property (p_cfg) else $error("global off");
    property p_msk; wrMask && &avmReq.byteenable[1:0] && avmReq.writedata[9:0] == '0
        |-> ##2 !hostIrqPin; endproperty
    a_msk: assert property (p_msk) else $error("masked irq");
endmodule : hcim_event_mask_props
`default_nettype wire

// ==== verif/hcim_host_model.sv ====
// Bus master model of the host driver processor.
// Assumes calls come after reset release.
`timescale 1ns/1ps
`default_nettype none
module hcim_host_model (
    input wire logic clk,
    output var hcim_pkg::hcim_avm_req_s req,
    input wire hcim_pkg::hcim_avm_rsp_s rsp
);
    import hcim_pkg::*;
    initial req = '0;
    // Flags read before buffer data; no DMA to set up
    task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        req <= '{a, !w, w, d, 4'hf};
        // Request stands until an edge samples waitrequest low
        do
            @(posedge clk);
        while (rsp.waitrequest);
        q = rsp.readdata;
        req <= '0;
    endtask : acc
endmodule : hcim_host_model
`default_nettype wire

// ==== verif/hcim_event_mask_tb.sv ====
// Self-checking bench for the host event mask block.
// Assumes the host model drives the register bus.
`timescale 1ns/1ps
`default_nettype none
`include "hcim_map.svh"
module hcim_event_mask_tb;
    import hcim_pkg::*;
    logic clk, rst_n, pin, irq;
    hcim_evt_s events;
    hcim_avm_req_s req;
    hcim_avm_rsp_s rsp;
    logic [31:0] q;
    int errors = 0, n_checks = 0, i, j;
    hcim_event_mask dut (.clk(clk), .rst_n(rst_n), .events(events), .transferEndPin(pin),
        .avmReq(req), .avmRsp(rsp), .hostIrqPin(irq));
    hcim_host_model host (.clk(clk), .req(req), .rsp(rsp));
    always #4 clk = ~clk;
    function automatic logic [31:0] expIrq(logic en, logic [9:0] f, logic [9:0] m);
        return {31'h0, en & |(f & m)};
    endfunction : expIrq
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic pulse(int b);
        @(posedge clk);
        events <= hcim_evt_s'(10'h1 << b);
        @(posedge clk);
        events <= '0;
        settle(3);
    endtask : pulse
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #200000;
        errors++;
        report_and_stop();
    end
    initial
    begin
        clk = 0;
        rst_n = 0;
        pin = 0;
        events = '0;
        void'($urandom(32'h4495));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        host.acc(0, `HCIM_ADDR_MASK, 0, q);
        chk(q, `HCIM_RST_MASK);
        host.acc(1, `HCIM_ADDR_MASK, 32'hffff, q);
        host.acc(0, `HCIM_ADDR_MASK, 0, q);
        chk(q, 32'h3ff);
        host.acc(1, `HCIM_ADDR_CFG, 1, q);
        for (i = 0; i < 10; i++)
        begin
            j = (i + 1 + $urandom % 9) % 10;
            host.acc(1, `HCIM_ADDR_MASK, 32'h1 << i, q);
            pulse(j);
            chk(irq, expIrq(1, 10'h1 << j, 10'h1 << i));
            pulse(i);
            chk(irq, 1);
            host.acc(0, `HCIM_ADDR_FLAGS, 0, q);
            chk(q, (32'h1 << i) | (32'h1 << j));
            host.acc(1, `HCIM_ADDR_FLAGS, 32'h3ff, q);
            settle(2);
            chk(irq, 0);
        end
        host.acc(1, `HCIM_ADDR_MASK, 32'h8, q);
        pin <= 1'b1;
        settle(6);
        chk(irq, 1);
        @(posedge clk);
        pin <= 1'b0;
        host.acc(1, `HCIM_ADDR_CFG, 0, q);
        settle(2);
        chk(irq, 0);
        host.acc(1, 10'h0fc, 32'hffff, q);
        host.acc(0, 10'h0fc, 0, q);
        chk(q, 0);
        report_and_stop();
    end
endmodule : hcim_event_mask_tb
bind hcim_event_mask hcim_event_mask_props u_props (.clk(clk), .rst_n(rst_n),
    .events(events), .transferEndPin(transferEndPin), .avmReq(avmReq),
    .avmRsp(avmRsp), .hostIrqPin(hostIrqPin));
`default_nettype wire
